// file: hdl/vrmp_pkg.sv
// Package for the virtual real mode protection checker: register map,
// control field positions, exception vectors and the request carriers.
// Assumes a single 50 MHz core clock domain for all users.
package vrmp_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses of aligned 32-bit words
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TSS_BASE = 8'h04;
  localparam logic [7:0] ADDR_TSS_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_PDBR = 8'h0c;
  localparam logic [7:0] ADDR_PAGE_INDEX = 8'h10;
  localparam logic [7:0] ADDR_PAGE_FRAME = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // ----------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------
  localparam int CTRL_PE_BIT = 0;
  localparam int CTRL_VM_BIT = 1;
  localparam int CTRL_PG_BIT = 2;
  localparam int CTRL_CPL_LSB = 4;
  localparam int CTRL_IO_PRIVILEGE_LEVEL_LSB = 8;
  localparam int FRAME_VALID_BIT = 31;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Architectural constants
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_NONE = 8'h00;
  localparam logic [7:0] VEC_INVALID_OPCODE = 8'h06;
  localparam logic [7:0] VEC_GENERAL_PROT = 8'h0d;
  localparam logic [31:0] TSS_BITMAP_PTR_OFF = 32'h0000_0066;
  localparam logic [31:0] TSS_BITMAP_PTR_END = 32'h0000_0067;
  localparam int SEG_SHIFT = 4;
  localparam logic [1:0] LEVEL_MOST = 2'h0;
  localparam logic [1:0] LEVEL_LEAST = 2'h3;
  localparam logic [4:0] BITS_PER_BYTE = 5'h08;

  // ----------------------------------------------------------------
  // Instruction classes and access widths
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CLS_NORMAL, CLS_PRIV, CLS_PROT_ONLY, CLS_PORT_IO, CLS_IFLAG,
    CLS_INT_N, CLS_FLAGS_PUSH, CLS_FLAGS_POP, CLS_INT_RET,
    CLS_INT3, CLS_INTO, CLS_BOUND
  } vrmp_class_t;

  typedef enum logic [1:0] {WIDTH_BYTE, WIDTH_WORD, WIDTH_DWORD} vrmp_width_t;

  typedef struct packed {
    vrmp_class_t cls;
    logic [15:0] seg;
    logic [31:0] offset;
    logic [15:0] port;
    vrmp_width_t width;
  } vrmp_req_t;

  typedef struct packed {
    logic fault;
    logic [7:0] vector;
    logic page_miss;
    logic [31:0] linear;
    logic [31:0] phys;
  } vrmp_resp_t;

endpackage

// file: hdl/vrmp_checker.sv
// Protection checker for virtual real address mode: address forming,
// instruction classification, I/O bitmap lookup and page frame mapping.
// Assumes a same-clock memory read port that answers with an ack pulse.
// Function
// - Virtual mode linear address is segment value shifted left four plus offset.
// - Virtual mode offsets above 64 Kbyte raise exception 13.
// - Virtual mode code runs at privilege level 3 with protected checks.
// - Privileged system instructions at privilege above 0 raise exception 13.
// - Protected-only instructions raise exception 6 in real or virtual mode.
// - Protected mode port I/O and interrupt flag instructions depend on I/O level.
// - Virtual mode INT n, flag set/clear, push, pop, return depend on I/O level.
// - Breakpoint, overflow interrupt and bounds check never get the I/O level check.
// - Virtual mode port I/O is checked against the task permission bitmap.
// - Bitmap pointer is the 16-bit word at offset 66H of the task segment.
// - One bitmap bit per byte port; clear permits, set raises exception 13.
// - Wide port accesses need every covering bit clear, else exception 13.
// - Bitmap bits beyond the task segment limit raise exception 13.
// - Reloading the page directory base flushes the translation buffer.
// - Task switches save and restore the page directory base.
// - Paged virtual mode maps 256 pages of 4 Kbyte anywhere physically.
// - Taking an exception from virtual mode clears the virtual mode flag.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module vrmp_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rd_data,
  input wire logic req_valid,
  output logic req_ready,
  input wire vrmp_pkg::vrmp_req_t req,
  output logic resp_valid,
  output vrmp_pkg::vrmp_resp_t resp,
  output logic mem_rd_req,
  output logic [31:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [15:0] mem_rd_data,
  input wire logic exc_taken,
  input wire logic ts_valid,
  input wire logic [31:0] ts_new_pdbr,
  output logic [31:0] ts_saved_pdbr,
  output logic tlb_flush
);
  import vrmp_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic pe_reg, vm_reg, pg_reg;
  logic [1:0] cpl_reg, io_privilege_level_reg;
  logic [31:0] tss_base_reg, tss_limit_reg, pdbr_reg, saved_pdbr_reg;
  logic [7:0] page_index_reg;
  logic [19:0] frame_mem [256];
  logic [255:0] frame_valid_reg;
  logic [7:0] last_vec_reg;
  logic last_fault_reg;
  logic [15:0] flush_cnt_reg;
  logic flush_reg;
  logic [31:0] rd_data_reg;

  wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  wire wr_pdbr = reg_wr && (reg_addr == ADDR_PDBR);
  wire wr_frame = reg_wr && (reg_addr == ADDR_PAGE_FRAME);
  wire flush_now = wr_pdbr || ts_valid;
  wire [31:0] ctrl_rd = {22'h0, io_privilege_level_reg, 2'h0, cpl_reg, 1'b0, pg_reg, vm_reg, pe_reg};
  wire [31:0] frame_rd = {frame_valid_reg[page_index_reg], 11'h0, frame_mem[page_index_reg]};
  wire [31:0] status_rd = {flush_cnt_reg, 7'h0, last_fault_reg, last_vec_reg};
  wire [31:0] rd_mux =
    (reg_addr == ADDR_CTRL) ? ctrl_rd :
    (reg_addr == ADDR_TSS_BASE) ? tss_base_reg :
    (reg_addr == ADDR_TSS_LIMIT) ? tss_limit_reg :
    (reg_addr == ADDR_PDBR) ? pdbr_reg :
    (reg_addr == ADDR_PAGE_INDEX) ? {24'h0, page_index_reg} :
    (reg_addr == ADDR_PAGE_FRAME) ? frame_rd :
    (reg_addr == ADDR_STATUS) ? status_rd : REG_RESET;

  // Our own fault answer counts as an exception taken from virtual mode.
  logic own_fault_taken;
  wire vm_clear = exc_taken || own_fault_taken;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pe_reg <= 1'b0;
      vm_reg <= 1'b0;
      pg_reg <= 1'b0;
      cpl_reg <= LEVEL_MOST;
      io_privilege_level_reg <= LEVEL_MOST;
      tss_base_reg <= REG_RESET;
      tss_limit_reg <= REG_RESET;
      page_index_reg <= 8'h00;
      rd_data_reg <= REG_RESET;
    end else begin
      rd_data_reg <= reg_rd ? rd_mux : REG_RESET;
      if (wr_ctrl) begin
        pe_reg <= reg_wr_data[CTRL_PE_BIT];
        pg_reg <= reg_wr_data[CTRL_PG_BIT];
        cpl_reg <= reg_wr_data[CTRL_CPL_LSB +: 2];
        io_privilege_level_reg <= reg_wr_data[CTRL_IO_PRIVILEGE_LEVEL_LSB +: 2];
      end
      // The hardware clear outranks a software write in the same cycle.
      if (vm_clear) begin
        vm_reg <= 1'b0;
      end else if (wr_ctrl) begin
        vm_reg <= reg_wr_data[CTRL_VM_BIT];
      end
      if (reg_wr && reg_addr == ADDR_TSS_BASE) begin
        tss_base_reg <= reg_wr_data;
      end
      if (reg_wr && reg_addr == ADDR_TSS_LIMIT) begin
        tss_limit_reg <= reg_wr_data;
      end
      if (reg_wr && reg_addr == ADDR_PAGE_INDEX) begin
        page_index_reg <= reg_wr_data[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Page directory base, task switch and translation flush
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pdbr_reg <= REG_RESET;
      saved_pdbr_reg <= REG_RESET;
      flush_reg <= 1'b0;
      flush_cnt_reg <= 16'h0000;
      frame_valid_reg <= '0;
    end else begin
      flush_reg <= flush_now;
      if (flush_now) begin
        flush_cnt_reg <= flush_cnt_reg + 16'h0001;
      end
      if (ts_valid) begin
        saved_pdbr_reg <= pdbr_reg;
        pdbr_reg <= ts_new_pdbr;
      end else if (wr_pdbr) begin
        pdbr_reg <= reg_wr_data;
      end
      // A frame written in the flush cycle survives the flush.
      if (wr_frame) begin
        frame_valid_reg <= (flush_now ? 256'h0 : frame_valid_reg)
                           | (256'h1 << page_index_reg);
      end else if (flush_now) begin
        frame_valid_reg <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wr_frame) begin
      frame_mem[page_index_reg] <= reg_wr_data[19:0];
    end
  end

  a_flush_pulse: assert property (flush_now |=> tlb_flush)
    else $error("translation flush did not follow a base reload");
  a_task_swap: assert property (ts_valid |=> ts_saved_pdbr == $past(pdbr_reg)
    && pdbr_reg == $past(ts_new_pdbr)) else $error("task switch base swap wrong");
  a_flush_clears: assert property (wr_pdbr && !wr_frame |=> frame_valid_reg == 256'h0)
    else $error("frame table survived a flush");

  // ----------------------------------------------------------------
  // Classification of an arriving request
  // ----------------------------------------------------------------
  wire is_vm = pe_reg && vm_reg;
  wire is_prot = pe_reg && !vm_reg;
  wire [1:0] cpl_eff = is_vm ? LEVEL_LEAST : (pe_reg ? cpl_reg : LEVEL_MOST);
  wire cls_iflag = (req.cls == CLS_IFLAG);
  wire cls_port = (req.cls == CLS_PORT_IO);
  // Breakpoint, overflow and bounds classes are left out of both lists.
  wire vm_sensitive = cls_iflag || req.cls == CLS_INT_N || req.cls == CLS_FLAGS_PUSH
                      || req.cls == CLS_FLAGS_POP || req.cls == CLS_INT_RET;
  wire fault_ud = (req.cls == CLS_PROT_ONLY) && !is_prot;
  wire fault_priv = (req.cls == CLS_PRIV) && (cpl_eff != LEVEL_MOST);
  wire fault_off = !is_prot && (req.offset[31:16] != 16'h0000);
  wire fault_piopl = is_prot && (cls_port || cls_iflag) && (cpl_eff > io_privilege_level_reg);
  wire fault_viopl = is_vm && vm_sensitive && (io_privilege_level_reg != LEVEL_LEAST);
  wire fault_gp = fault_priv || fault_off || fault_piopl || fault_viopl;
  wire need_map = is_vm && cls_port && !fault_gp;
  wire ptr_beyond = tss_limit_reg < TSS_BITMAP_PTR_END;

  wire [31:0] seg_base = {12'h000, req.seg, 4'h0};
  wire [31:0] lin_rm = seg_base + {16'h0000, req.offset[15:0]};
  wire [31:0] linear = is_prot ? req.offset : lin_rm;
  wire [7:0] page_idx = linear[19:12];
  wire page_hit = frame_valid_reg[page_idx] && (linear[31:20] == 12'h000);
  wire paged = pg_reg && is_vm;
  wire [31:0] phys = !paged ? linear :
                     (page_hit ? {frame_mem[page_idx], linear[11:0]} : REG_RESET);

  wire [7:0] vec_now = fault_ud ? VEC_INVALID_OPCODE :
                       (fault_gp || (need_map && ptr_beyond)) ? VEC_GENERAL_PROT : VEC_NONE;

  // ----------------------------------------------------------------
  // Bitmap lookup sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_MAP, ST_RESP} vrmp_state_t;
  vrmp_state_t state_reg, state_next;
  vrmp_resp_t resp_reg;
  logic [31:0] mem_addr_reg;
  logic [15:0] q_port;
  vrmp_width_t q_width;
  logic q_vm;

  wire accept = req_valid && (state_reg == ST_IDLE);
  wire [16:0] byte_off = {1'b0, mem_rd_data} + {4'h0, q_port[15:3]};
  wire [4:0] width_bytes = (q_width == WIDTH_DWORD) ? 5'h04 :
                           (q_width == WIDTH_WORD) ? 5'h02 : 5'h01;
  wire two_bytes = ({2'h0, q_port[2:0]} + width_bytes) > BITS_PER_BYTE;
  wire [16:0] last_off = byte_off + {16'h0000, two_bytes};
  wire map_beyond = {15'h0000, last_off} > tss_limit_reg;
  wire [15:0] map_bits = mem_rd_data >> q_port[2:0];
  wire [3:0] width_mask = (q_width == WIDTH_DWORD) ? 4'hf :
                          (q_width == WIDTH_WORD) ? 4'h3 : 4'h1;
  wire map_denied = |(map_bits[3:0] & width_mask);
  wire mem_ack_ptr = (state_reg == ST_PTR) && mem_rd_ack;
  wire mem_ack_map = (state_reg == ST_MAP) && mem_rd_ack;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = (need_map && !ptr_beyond && !fault_ud) ? ST_PTR : ST_RESP;
        end
      end
      ST_PTR: begin
        if (mem_rd_ack) begin
          state_next = map_beyond ? ST_RESP : ST_MAP;
        end
      end
      ST_MAP: begin
        if (mem_rd_ack) begin
          state_next = ST_RESP;
        end
      end
      ST_RESP: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      resp_reg <= '0;
      mem_addr_reg <= REG_RESET;
      q_port <= 16'h0000;
      q_width <= WIDTH_BYTE;
      q_vm <= 1'b0;
      last_vec_reg <= VEC_NONE;
      last_fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        resp_reg <= '{fault: vec_now != VEC_NONE, vector: vec_now,
                      page_miss: paged && !page_hit, linear: linear, phys: phys};
        mem_addr_reg <= tss_base_reg + TSS_BITMAP_PTR_OFF;
        q_port <= req.port;
        q_width <= req.width;
        q_vm <= is_vm;
      end
      if (mem_ack_ptr) begin
        mem_addr_reg <= tss_base_reg + {15'h0000, byte_off};
        if (map_beyond) begin
          resp_reg.fault <= 1'b1;
          resp_reg.vector <= VEC_GENERAL_PROT;
        end
      end
      if (mem_ack_map && map_denied) begin
        resp_reg.fault <= 1'b1;
        resp_reg.vector <= VEC_GENERAL_PROT;
      end
      if (state_reg == ST_RESP) begin
        last_vec_reg <= resp_reg.vector;
        last_fault_reg <= resp_reg.fault;
      end
    end
  end

  assign own_fault_taken = (state_reg == ST_RESP) && resp_reg.fault && q_vm;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready = (state_reg == ST_IDLE);
  assign resp_valid = (state_reg == ST_RESP);
  assign resp = resp_reg;
  assign mem_rd_req = (state_reg == ST_PTR) || (state_reg == ST_MAP);
  assign mem_rd_addr = mem_addr_reg;
  assign reg_rd_data = rd_data_reg;
  assign ts_saved_pdbr = saved_pdbr_reg;
  assign tlb_flush = flush_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // The bitmap walk delays the answer, but the linear address is latched at accept.
  a_seg_shift: assert property (accept && !is_prot
    |=> resp.linear == {12'h000, $past(req.seg), 4'h0} + {16'h0000, $past(req.offset[15:0])})
    else $error("segment base not formed by shift and add");
  a_offset_limit: assert property (accept && is_vm && req.offset > 32'h0000_ffff
    && req.cls != CLS_PROT_ONLY |=> resp.fault && resp.vector == VEC_GENERAL_PROT)
    else $error("oversized offset did not fault");
  a_priv_instr: assert property (accept && req.cls == CLS_PRIV && (is_vm || cpl_reg != 2'h0)
    && pe_reg |=> resp_valid && resp.vector == VEC_GENERAL_PROT)
    else $error("privileged instruction passed above level zero");
  a_prot_only: assert property (accept && req.cls == CLS_PROT_ONLY && !is_prot
    |=> resp_valid && resp.vector == VEC_INVALID_OPCODE)
    else $error("protected-only instruction did not raise 6");
  a_prot_io_privilege_level: assert property (accept && is_prot && req.cls == CLS_IFLAG
    && cpl_reg > io_privilege_level_reg |=> resp.fault && resp.vector == VEC_GENERAL_PROT)
    else $error("protected interrupt flag bypassed I/O level");
  a_vm_io_privilege_level: assert property (accept && is_vm && req.cls == CLS_FLAGS_POP
    && io_privilege_level_reg != 2'h3 && req.offset[31:16] == 16'h0000 |=> resp.fault)
    else $error("virtual mode flags pop bypassed I/O level");
  a_no_io_privilege_level: assert property (accept && req.cls inside {CLS_INT3, CLS_INTO, CLS_BOUND}
    && req.offset[31:16] == 16'h0000 |=> resp_valid && !resp.fault)
    else $error("exempt instruction faulted");
  a_ptr_fetch: assert property (accept && need_map && !ptr_beyond |=> mem_rd_req
    && mem_rd_addr == tss_base_reg + 32'h0000_0066)
    else $error("bitmap pointer fetched from wrong offset");
  a_map_fault: assert property (mem_ack_map && map_denied |=> resp_valid && resp.fault)
    else $error("set bitmap bit did not fault");
  a_vm_clear: assert property (exc_taken |=> !vm_reg)
    else $error("virtual mode flag not cleared on exception");

  c_bitmap_pass: cover property (mem_ack_map && !map_denied ##1 resp_valid);
  c_bitmap_limit: cover property (mem_ack_ptr && map_beyond);
  c_vm_sensitive: cover property (accept && is_vm && vm_sensitive);
  c_task_switch: cover property (ts_valid ##1 tlb_flush);

endmodule

`default_nettype wire

// file: dv/vrmp_checker_tb.sv
// Self-checking bench for the virtual real mode protection checker.
// Assumes the bench answers the memory read port itself, from a small task segment image.
`timescale 1ns/1ns
`default_nettype none

module vrmp_checker_tb;
  import vrmp_pkg::*;
  typedef struct packed {
    logic [11:0] ctrl; vrmp_class_t cls; logic [15:0] seg; logic [31:0] off;
    logic [15:0] port; vrmp_width_t w; logic [7:0] vec;
  } vrmp_row_t;
  localparam logic [31:0] TSS_AT = 32'h0000_1000;
  localparam int MODE_R = 0;
  localparam int MODE_P = 1;
  localparam int MODE_V = 3;
  logic clk, rst_n, reg_wr, reg_rd, req_valid, req_ready, resp_valid, mem_rd_req, mem_rd_ack;
  logic exc_taken, ts_valid, tlb_flush;
  logic [7:0] reg_addr;
  logic [31:0] reg_wr_data, reg_rd_data, mem_rd_addr, ts_new_pdbr, ts_saved_pdbr;
  logic [15:0] mem_rd_data;
  vrmp_req_t req;
  vrmp_resp_t resp, rs;
  vrmp_row_t rows[$];
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  vrmp_class_t sens[5] = '{CLS_INT_N, CLS_IFLAG, CLS_FLAGS_PUSH, CLS_FLAGS_POP, CLS_INT_RET};
  vrmp_class_t free3[3] = '{CLS_INT3, CLS_INTO, CLS_BOUND};

  vrmp_checker uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .resp_valid(resp_valid), .resp(resp),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack),
    .mem_rd_data(mem_rd_data), .exc_taken(exc_taken), .ts_valid(ts_valid),
    .ts_new_pdbr(ts_new_pdbr), .ts_saved_pdbr(ts_saved_pdbr), .tlb_flush(tlb_flush));

  // ----------------------------------------------------------------
  // Clock, memory image and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Bitmap at 80h: ports 0-3, 8 and 15 denied; byte 82h is the all-ones end marker.
  function automatic logic [7:0] tss_byte(input logic [31:0] o);
    case (o)
      32'h0000_0066: return 8'h80;
      32'h0000_0067: return 8'h00;
      32'h0000_0080: return 8'h0f;
      32'h0000_0081: return 8'h81;
      32'h0000_0082: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction

  // Beyond the limit the image reads as permitted, so only the limit check can fault.
  always @(posedge clk) begin
    mem_rd_ack <= mem_rd_req && !mem_rd_ack;
    mem_rd_data <= {tss_byte(mem_rd_addr - TSS_AT + 1), tss_byte(mem_rd_addr - TSS_AT)};
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (exp !== got) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wr_data <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(what, exp, reg_rd_data);
  endtask

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) exc_taken <= 1'b1;
    else ts_valid <= 1'b1;
    @(posedge clk);
    exc_taken <= 1'b0; ts_valid <= 1'b0;
  endtask

  task automatic do_req(input vrmp_req_t q, output vrmp_resp_t r);
    int n;
    n = 0;
    @(posedge clk);
    req <= q; req_valid <= 1'b1;
    @(negedge clk);
    while (!req_ready) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    while (resp_valid !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    if (n == 20) chk("resp_valid", 1, 0);
    r = resp;
  endtask

  function automatic logic [11:0] md(input int m, input int cur, input int io);
    return 12'(m) | 12'(cur << CTRL_CPL_LSB) | 12'(io << CTRL_IO_PRIVILEGE_LEVEL_LSB);
  endfunction

  task automatic add(input logic [11:0] c, input vrmp_class_t k, input logic [15:0] s,
                     input logic [31:0] o, input logic [15:0] p, input vrmp_width_t w,
                     input logic [7:0] v);
    rows.push_back('{c, k, s, o, p, w, v});
  endtask

  task automatic io(input int lvl, input logic [15:0] p, input vrmp_width_t w, input logic [7:0] v);
    add(md(MODE_V, 0, lvl), CLS_PORT_IO, 16'h0040, 32'h0000_0008, p, w, v);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] lin;
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wr_data = 32'h0;
    req_valid = 1'b0; req = '0; mem_rd_ack = 1'b0; mem_rd_data = 16'h0;
    exc_taken = 1'b0; ts_valid = 1'b0; ts_new_pdbr = 32'h0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk("ready_in_reset", 1, req_ready);
    chk("resp_valid_in_reset", 0, resp_valid);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, REG_RESET, "ctrl_reset");
    rd(8'h1c, 32'h0, "unmapped_read");
    wr(ADDR_TSS_BASE, TSS_AT);
    wr(ADDR_TSS_LIMIT, 32'h0000_0082);
    add(md(MODE_V, 0, 0), CLS_NORMAL, 16'h1234, 32'h0000_0010, 0, WIDTH_BYTE, VEC_NONE);
    add(md(MODE_V, 0, 0), CLS_NORMAL, 16'h1234, 32'h0001_0000, 0, WIDTH_BYTE, VEC_GENERAL_PROT);
    add(md(MODE_R, 0, 0), CLS_NORMAL, 16'hffff, 32'h0000_ffff, 0, WIDTH_BYTE, VEC_NONE);
    add(md(MODE_V, 0, 3), CLS_PRIV, 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_GENERAL_PROT);
    add(md(MODE_R, 0, 0), CLS_PRIV, 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_NONE);
    add(md(MODE_P, 1, 3), CLS_PRIV, 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_GENERAL_PROT);
    add(md(MODE_P, 0, 0), CLS_PRIV, 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_NONE);
    add(md(MODE_R, 0, 0), CLS_PROT_ONLY, 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_INVALID_OPCODE);
    add(md(MODE_V, 0, 3), CLS_PROT_ONLY, 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_INVALID_OPCODE);
    add(md(MODE_P, 3, 0), CLS_PROT_ONLY, 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_NONE);
    add(md(MODE_P, 3, 2), CLS_PORT_IO, 16'h0, 32'h0, 3, WIDTH_BYTE, VEC_GENERAL_PROT);
    add(md(MODE_P, 2, 2), CLS_PORT_IO, 16'h0, 32'h0, 3, WIDTH_BYTE, VEC_NONE);
    add(md(MODE_P, 3, 0), CLS_IFLAG, 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_GENERAL_PROT);
    add(md(MODE_P, 1, 1), CLS_IFLAG, 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_NONE);
    foreach (sens[i]) begin
      add(md(MODE_V, 0, 2), sens[i], 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_GENERAL_PROT);
      add(md(MODE_V, 0, 3), sens[i], 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_NONE);
      if (i > 1) add(md(MODE_P, 3, 0), sens[i], 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_NONE);
    end
    foreach (free3[i]) begin
      add(md(MODE_V, 0, 0), free3[i], 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_NONE);
      add(md(MODE_P, 3, 0), free3[i], 16'h0, 32'h0, 0, WIDTH_BYTE, VEC_NONE);
    end
    io(0, 4, WIDTH_DWORD, VEC_NONE); io(0, 6, WIDTH_WORD, VEC_NONE);
    io(0, 6, WIDTH_DWORD, VEC_GENERAL_PROT); io(3, 3, WIDTH_BYTE, VEC_GENERAL_PROT);
    io(0, 9, WIDTH_WORD, VEC_NONE); io(0, 14, WIDTH_BYTE, VEC_NONE);
    io(0, 15, WIDTH_BYTE, VEC_GENERAL_PROT); io(0, 16, WIDTH_BYTE, VEC_GENERAL_PROT);
    io(0, 24, WIDTH_BYTE, VEC_GENERAL_PROT);
    foreach (rows[i]) begin
      wr(ADDR_CTRL, {20'h0, rows[i].ctrl});
      do_req('{rows[i].cls, rows[i].seg, rows[i].off, rows[i].port, rows[i].w}, rs);
      lin = (rows[i].ctrl[1] || !rows[i].ctrl[0]) ?
            {12'h0, rows[i].seg, 4'h0} + {16'h0, rows[i].off[15:0]} : rows[i].off;
      chk("fault", {31'h0, rows[i].vec != VEC_NONE}, {31'h0, rs.fault});
      chk("vector", {24'h0, rows[i].vec}, {24'h0, rs.vector});
      chk("linear", lin, rs.linear);
    end
    wr(ADDR_TSS_LIMIT, 32'h0000_0065);
    wr(ADDR_CTRL, {20'h0, md(MODE_V, 0, 3)});
    do_req('{CLS_PORT_IO, 16'h0, 32'h0, 16'h0004, WIDTH_BYTE}, rs);
    chk("vector_short_limit", {24'h0, VEC_GENERAL_PROT}, {24'h0, rs.vector});
    wr(ADDR_TSS_LIMIT, 32'h0000_0070);
    wr(ADDR_CTRL, {20'h0, md(MODE_V, 0, 3)});
    do_req('{CLS_PORT_IO, 16'h0, 32'h0, 16'h0004, WIDTH_BYTE}, rs);
    chk("vector_map_past_limit", {24'h0, VEC_GENERAL_PROT}, {24'h0, rs.vector});
    rd(ADDR_CTRL, 32'h0000_0301, "ctrl_after_fault");
    wr(ADDR_CTRL, {20'h0, md(MODE_V, 0, 3)});
    pulse(0);
    rd(ADDR_CTRL, 32'h0000_0301, "ctrl_after_exc");
    wr(ADDR_PAGE_INDEX, 32'h0000_0012);
    wr(ADDR_PAGE_FRAME, 32'h000a_bcde);
    rd(ADDR_PAGE_FRAME, 32'h800a_bcde, "frame_read");
    wr(ADDR_CTRL, {20'h0, md(MODE_V, 0, 3) | 12'h004});
    do_req('{CLS_NORMAL, 16'h1200, 32'h0000_0345, 16'h0, WIDTH_BYTE}, rs);
    chk("phys_hit", 32'habcd_e345, rs.phys);
    chk("miss_hit", 0, {31'h0, rs.page_miss});
    do_req('{CLS_NORMAL, 16'h1300, 32'h0000_0345, 16'h0, WIDTH_BYTE}, rs);
    chk("miss_other", 1, {31'h0, rs.page_miss});
    wr(ADDR_PDBR, 32'h0000_5000);
    @(negedge clk);
    chk("flush_pdbr", 1, {31'h0, tlb_flush});
    do_req('{CLS_NORMAL, 16'h1200, 32'h0000_0345, 16'h0, WIDTH_BYTE}, rs);
    chk("miss_after_flush", 1, {31'h0, rs.page_miss});
    ts_new_pdbr <= 32'h0000_7000;
    pulse(1);
    @(negedge clk);
    chk("saved_pdbr", 32'h0000_5000, ts_saved_pdbr);
    chk("flush_switch", 1, {31'h0, tlb_flush});
    rd(ADDR_PDBR, 32'h0000_7000, "pdbr_after_switch");
    rd(ADDR_STATUS, 32'h0002_0000, "status_flush_count");
    summarize();
  end
endmodule

`default_nettype wire
